/* rtl/csq_pkg.sv */
// Purpose: Shared constants and types for the clock stop sequencer
// Assumes: Single cpu clock at 100 MHz
// Notes: Domain index equals stop number
package csq_pkg;

    localparam int NUM_DOMAINS = 32;
    localparam int NUM_CORES = 8;
    localparam int DOM_IDX_W = 5;
    localparam int DELAY_W = 7;
    localparam int CORE_DOM_LSB = 0;

    localparam int CLK_PERIOD_NS = 10;
    localparam int STOP_GAP_NS = 1280;
    localparam int STOP_GAP_CYC = STOP_GAP_NS / CLK_PERIOD_NS;

    // Counter value v gives a gap of v+1 cycles
    localparam logic [DELAY_W-1:0] DELAY_RESET = DELAY_W'(STOP_GAP_CYC - 1);
    localparam logic [NUM_DOMAINS-1:0] DOMAIN_SEL_RESET = 32'h0000_0001;

    typedef enum logic [1:0] {
        CSQ_IDLE = 2'b00,
        CSQ_STOPPING = 2'b01,
        CSQ_STOPPED = 2'b10,
        CSQ_RELEASING = 2'b11
    } csq_state_t;

    typedef struct packed {
        logic [5:0] spare;
        logic [DOM_IDX_W-1:0] seqPtr;
        logic softMode;
        logic clocksStopped;
        logic busy;
        csq_state_t state;
    } csq_status_t;

    // Lowest set bit; an empty select behaves as domain 0 first
    function automatic logic [DOM_IDX_W-1:0] csq_first_domain(input logic [NUM_DOMAINS-1:0] sel);
        logic [DOM_IDX_W-1:0] idx;
        idx = '0;
        for (int i = NUM_DOMAINS - 1; i >= 0; i--) begin
            if (sel[i]) begin
                idx = DOM_IDX_W'(i);
            end
        end
        return idx;
    endfunction : csq_first_domain

endpackage : csq_pkg

/* rtl/csq_gap_timer.sv */
// Purpose: Programmable gap between successive domain stop steps
// Assumes: delay is stable while a sequence runs
// Notes: Ticks every delay+1 cycles after a restart
`timescale 1ns/1ps
`default_nettype none
module csq_gap_timer
    import csq_pkg::*;
#(
    parameter int W = DELAY_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [W-1:0] delay,
    output logic tick
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    always_comb begin
        tick = (count_q == '0) && !restart;
        if (restart || tick) begin
            count_d = delay;
        end else begin
            count_d = count_q - W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : csq_gap_timer
`default_nettype wire

/* rtl/csq_clock_stop_sequencer.sv */
// Purpose: Hard and soft clock stop sequencer with serial, parallel and mixed order
// Assumes: All request inputs are one-cycle pulses from logic on ref_clk
// Notes: Reset, clock control and test control clocks have no stop output here
// Operation
// R1: Flush request stops clocks; flush completion restarts them.
// R2: Hard stop proceeds at once, never waiting for quiescence.
// R3: Soft stop only touches cores, each stopped once it reports quiescent.
// R4: Several cores can soft stop together and resume after restart.
// R5: Serial stops are spaced by 128 cycles by default.
// R6: Selected domain stops first, the rest follow in fixed order.
// R7: Parallel domains all stop on the same cycle.
// R8: Controller sets all select bits for a fully parallel stop.
// R9: Thirty-two bit select register loaded by its own instruction; bit is stop number.
// R10: A single set bit marks the serial start domain.
// R11: Set bits stop together, clear bits follow serially.
// R12: Hard stop covers all 32 domains, soft stop cores only; never control unit clocks.
// R13: Hard stop triggers: flush, hard stop instruction, debug event.
// R14: Sequencer state readable through a status instruction.
// R15: Controller dumps scan only after status shows clocks stopped.
// R16: Clocks restart only on the clock start instruction or flush completion.
// R17: Seven-bit programmable gap, reset 128 cycles, zero means one cycle.
// R18: Serial order wraps round until it reaches the first domain.
// R19: Release proceeds in sequence from the selected start domain.
// R20: Stop numbers 0 to 7 are the eight core domains.
// R21: Stopped flag sets when all selected stops are on, clears at restart.
// R22: Stop requests during a sequence are ignored until restart. The code keeps ignoring them until the release walk returns to idle.
`timescale 1ns/1ps
`default_nettype none
module csq_clock_stop_sequencer
    import csq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hardStopInstr,
    input wire logic softStopInstr,
    input wire logic clockStartInstr,
    input wire logic domainLoadInstr,
    input wire logic [NUM_DOMAINS-1:0] domainData,
    input wire logic delayLoadInstr,
    input wire logic [DELAY_W-1:0] delayData,
    input wire logic statusReadInstr,
    input wire logic flushReq,
    input wire logic flushDone,
    input wire logic debugHardReq,
    input wire logic [NUM_CORES-1:0] debugSoftReq,
    input wire logic [NUM_CORES-1:0] coreSelect,
    input wire logic [NUM_CORES-1:0] coreQuiescent,
    output logic [NUM_DOMAINS-1:0] domainStop,
    output logic clocksStopped,
    output csq_status_t statusData,
    output logic statusValid,
    output logic [NUM_DOMAINS-1:0] domainSelRead
);

    csq_state_t state_q, state_d;
    logic [NUM_DOMAINS-1:0] seqStop_q, seqStop_d;
    logic [DOM_IDX_W-1:0] ptr_q, ptr_d;
    logic [DOM_IDX_W-1:0] startPtr_q, startPtr_d;
    logic [DOM_IDX_W-1:0] nextPtr;
    logic [DOM_IDX_W-1:0] firstDom;
    logic softMode_q, softMode_d;
    logic [NUM_CORES-1:0] targets_q, targets_d;
    logic [NUM_CORES-1:0] coreHeld_q, coreHeld_d;
    logic [NUM_DOMAINS-1:0] domainSel_q, domainSel_d;
    logic [NUM_DOMAINS-1:0] selEff;
    logic [DELAY_W-1:0] delay_q, delay_d;
    logic [NUM_DOMAINS-1:0] domainStop_q, domainStop_d;
    logic clocksStopped_q, clocksStopped_d;
    csq_status_t statusData_q, statusData_d;
    logic statusValid_q;
    logic hardReq;
    logic softReq;
    logic restartReq;
    logic timerRestart;
    logic tick;

    assign hardReq = hardStopInstr || flushReq || debugHardReq; // [R1] [R13]
    assign softReq = softStopInstr || (|debugSoftReq);
    assign restartReq = clockStartInstr || flushDone; // [R16] [R1]
    assign selEff = (domainSel_q == '0) ? DOMAIN_SEL_RESET : domainSel_q;
    assign firstDom = csq_first_domain(selEff); // [R10]
    assign nextPtr = ptr_q + DOM_IDX_W'(1);

    csq_gap_timer #(
        .W(DELAY_W)
    ) u_gap_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .restart(timerRestart),
        .delay(delay_q),
        .tick(tick)
    );

    // Sequencer
    always_comb begin
        state_d = state_q;
        seqStop_d = seqStop_q;
        ptr_d = ptr_q;
        startPtr_d = startPtr_q;
        softMode_d = softMode_q;
        targets_d = targets_q;
        timerRestart = 1'b0;
        case (state_q)
            CSQ_IDLE: begin
                if (hardReq || softReq) begin
                    // Hard takes priority when both arrive together
                    state_d = CSQ_STOPPING;
                    softMode_d = !hardReq;
                    targets_d = softStopInstr ? coreSelect : debugSoftReq; // [R4]
                    startPtr_d = firstDom; // [R6]
                    ptr_d = firstDom;
                    seqStop_d = selEff; // [R7] [R11] [R2]
                    timerRestart = 1'b1;
                end
            end
            CSQ_STOPPING: begin
                // New stop requests fall through here unheard
                if (restartReq) begin // [R22]
                    state_d = CSQ_RELEASING;
                    ptr_d = startPtr_q;
                    seqStop_d[startPtr_q] = 1'b0; // [R19]
                    timerRestart = 1'b1;
                end else if (tick) begin // [R5] [R17]
                    ptr_d = nextPtr;
                    if (nextPtr == startPtr_q) begin // [R18]
                        state_d = CSQ_STOPPED;
                    end else begin
                        seqStop_d[nextPtr] = 1'b1; // [R6] [R11]
                    end
                end
            end
            CSQ_STOPPED: begin
                if (restartReq) begin // [R16]
                    state_d = CSQ_RELEASING;
                    ptr_d = startPtr_q;
                    seqStop_d[startPtr_q] = 1'b0; // [R19]
                    timerRestart = 1'b1;
                end
            end
            CSQ_RELEASING: begin
                if (tick) begin
                    ptr_d = nextPtr;
                    if (nextPtr == startPtr_q) begin
                        state_d = CSQ_IDLE;
                        seqStop_d = '0;
                        targets_d = '0;
                        softMode_d = 1'b0;
                    end else begin
                        seqStop_d[nextPtr] = 1'b0; // [R19]
                    end
                end
            end
            default: begin
                state_d = CSQ_IDLE;
                seqStop_d = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= CSQ_IDLE;
            seqStop_q <= '0;
            ptr_q <= '0;
            startPtr_q <= '0;
            softMode_q <= 1'b0;
            targets_q <= '0;
        end else begin
            state_q <= state_d;
            seqStop_q <= seqStop_d;
            ptr_q <= ptr_d;
            startPtr_q <= startPtr_d;
            softMode_q <= softMode_d;
            targets_q <= targets_d;
        end
    end

    // Stop outputs and flags
    always_comb begin
        // A core is held stopped only after it reported quiescent; it stays held despite later activity
        coreHeld_d = '0;
        if (softMode_q) begin
            coreHeld_d = (coreHeld_q | (seqStop_q[CORE_DOM_LSB +: NUM_CORES] & targets_q & coreQuiescent))
                & seqStop_q[CORE_DOM_LSB +: NUM_CORES]; // [R3] [R20]
        end
        if (softMode_q) begin
            domainStop_d = '0;
            domainStop_d[CORE_DOM_LSB +: NUM_CORES] = coreHeld_q; // [R3] [R12]
        end else begin
            domainStop_d = seqStop_q; // [R2] [R12]
        end
        clocksStopped_d = (state_q == CSQ_STOPPED) && !restartReq
            && (softMode_q ? (coreHeld_q == targets_q) : (domainStop_q == seqStop_q)); // [R21]
        domainSel_d = domainLoadInstr ? domainData : domainSel_q; // [R9]
        delay_d = delayLoadInstr ? delayData : delay_q; // [R17]
        statusData_d = statusData_q;
        if (statusReadInstr) begin // [R14]
            statusData_d.spare = '0;
            statusData_d.seqPtr = ptr_q;
            statusData_d.softMode = softMode_q;
            statusData_d.clocksStopped = clocksStopped_q;
            statusData_d.busy = (state_q != CSQ_IDLE);
            statusData_d.state = state_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            coreHeld_q <= '0;
            domainStop_q <= '0;
            clocksStopped_q <= 1'b0;
            domainSel_q <= DOMAIN_SEL_RESET;
            delay_q <= DELAY_RESET;
            statusData_q <= '0;
            statusValid_q <= 1'b0;
        end else begin
            coreHeld_q <= coreHeld_d;
            domainStop_q <= domainStop_d;
            clocksStopped_q <= clocksStopped_d;
            domainSel_q <= domainSel_d;
            delay_q <= delay_d;
            statusData_q <= statusData_d;
            statusValid_q <= statusReadInstr;
        end
    end

    assign domainStop = domainStop_q;
    assign clocksStopped = clocksStopped_q;
    assign statusData = statusData_q;
    assign statusValid = statusValid_q;
    assign domainSelRead = domainSel_q;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [7:0] sinceStep_q;
    always_ff @(posedge ref_clk) begin
        if (rst || timerRestart || tick) begin
            sinceStep_q <= '0;
        end else if (sinceStep_q != 8'hff) begin
            sinceStep_q <= sinceStep_q + 8'h01;
        end
    end

    a_hard_triggers: assert property ( // [R13]
        (state_q == CSQ_IDLE) && hardReq |=> (state_q == CSQ_STOPPING) && !softMode_q)
        else $error("hard trigger did not start a hard stop");
    a_parallel_same_cycle: assert property ( // [R7]
        (state_q == CSQ_IDLE) && hardReq |=> ##1 ((domainStop_q & selEff) == selEff))
        else $error("selected domains not stopped together");
    a_gap_spacing: assert property ( // [R5]
        (state_q == CSQ_STOPPING) && tick && !timerRestart |-> (sinceStep_q == 8'(delay_q)))
        else $error("serial stop gap differs from programmed delay");
    a_serial_order: assert property ( // [R18]
        (state_q == CSQ_STOPPING) && tick && !restartReq && (nextPtr != startPtr_q)
        |=> seqStop_q[$past(nextPtr)] && (ptr_q == $past(ptr_q) + 5'd1))
        else $error("serial step skipped a domain");
    a_soft_quiet: assert property ( // [R3]
        softMode_q |-> ((coreHeld_q & ~$past(coreHeld_q) & ~$past(coreQuiescent)) == '0))
        else $error("core held stopped without quiescence");
    a_soft_cores_only: assert property ( // [R12]
        softMode_q |-> ##1 (domainStop_q[NUM_DOMAINS-1:NUM_CORES] == '0))
        else $error("soft stop reached a non-core domain");
    a_busy_ignore: assert property ( // [R22]
        (state_q == CSQ_STOPPED) && hardReq && !restartReq |=> (state_q == CSQ_STOPPED))
        else $error("stop request disturbed a stopped sequencer");
    a_start_restart: assert property ( // [R16]
        (state_q == CSQ_STOPPED) && restartReq |=> (state_q == CSQ_RELEASING) && !seqStop_q[startPtr_q])
        else $error("restart did not release start domain");
    a_stopped_flag: assert property ( // [R21]
        clocksStopped_q |-> ($past(state_q) == CSQ_STOPPED) && !$past(restartReq))
        else $error("stopped flag outside stopped state");
    a_select_load: assert property ( // [R9]
        domainLoadInstr |=> (domainSelRead == $past(domainData)))
        else $error("select register did not load");
    a_delay_zero: assert property ( // [R17]
        (delay_q == 7'h00) && (state_q == CSQ_STOPPING) && !timerRestart |-> tick)
        else $error("zero delay did not step every cycle");
    a_release_order: assert property ( // [R19]
        (state_q == CSQ_RELEASING) && tick && (nextPtr != startPtr_q) |=> !seqStop_q[$past(nextPtr)])
        else $error("release step left a domain stopped");
    a_restart_only: assert property ( // [R16]
        (state_q == CSQ_STOPPED) && !restartReq |=> (state_q == CSQ_STOPPED))
        else $error("stopped clocks released without a start request");
    a_soft_targets: assert property ( // [R3]
        softMode_q |-> ((coreHeld_q & ~targets_q) == '0))
        else $error("soft stop held a core that was not targeted");
    a_flag_clear: assert property ( // [R21]
        restartReq && (state_q != CSQ_IDLE) |=> !clocksStopped_q)
        else $error("stopped flag survived a restart");
    a_status_snapshot: assert property ( // [R14]
        statusReadInstr |=> statusValid_q && (statusData_q.state == $past(state_q)))
        else $error("status read missed the sequencer state");
    a_hard_all_stop: assert property ( // [R18]
        (state_q == CSQ_STOPPED) && !softMode_q |-> (domainStop_q == '1))
        else $error("hard stop ended with a domain still running");

    c_hard_stopped: cover property ((state_q == CSQ_STOPPING) && !softMode_q ##[1:1000] clocksStopped_q);
    c_soft_stopped: cover property (softMode_q && clocksStopped_q && (targets_q != '0));
    c_flush_cycle: cover property ((state_q == CSQ_IDLE) && flushReq ##[1:1000] flushDone);
    c_release_done: cover property ((state_q == CSQ_RELEASING) ##1 (state_q == CSQ_IDLE));
    c_serial_wrap: cover property ((state_q == CSQ_STOPPING) ##1 (state_q == CSQ_STOPPED));

endmodule : csq_clock_stop_sequencer
`default_nettype wire

/* tb/csq_core_model.sv */
// Purpose: Core activity model facing the stop sequencer
// Assumes: parkReq comes from the bench
// Notes: lat picks a prompt or a slow settle
`timescale 1ns/1ps
`default_nettype none
module csq_core_model
    import csq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [NUM_CORES-1:0] parkReq,
    input wire logic [2:0] lat,
    output logic [NUM_CORES-1:0] coreQuiescent
);
    logic [NUM_CORES-1:0] settle_q [8];

    // A running core drops quiescence at once; settling takes lat+1 cycles
    always_ff @(posedge ref_clk) begin
        settle_q[0] <= rst ? '0 : parkReq;
        for (int i = 1; i < 8; i++) begin
            settle_q[i] <= rst ? '0 : settle_q[i - 1] & parkReq;
        end
    end

    assign coreQuiescent = settle_q[lat] & parkReq;
endmodule : csq_core_model
`default_nettype wire

/* tb/csq_clock_stop_sequencer_test.sv */
// Purpose: Self-checking bench for the clock stop sequencer
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Release order is compared exactly only for a single start bit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module csq_clock_stop_sequencer_test;
    import csq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hardStopInstr = 1'b0, softStopInstr = 1'b0, clockStartInstr = 1'b0, domainLoadInstr = 1'b0;
    logic delayLoadInstr = 1'b0, statusReadInstr = 1'b0, flushReq = 1'b0, flushDone = 1'b0, debugHardReq = 1'b0;
    logic [31:0] domainData = '0;
    logic [6:0] delayData = '0;
    logic [7:0] debugSoftReq = '0, coreSelect = '0, parkReq = '0, coreQuiescent;
    logic [2:0] lat = '0;
    logic [31:0] domainStop, domainSelRead;
    logic clocksStopped, statusValid;
    csq_status_t statusData;
    int fails = 0;
    int nTests = 0;

    always #5 ref_clk = ~ref_clk;

    csq_clock_stop_sequencer dut (.ref_clk(ref_clk), .rst(rst), .hardStopInstr(hardStopInstr),
        .softStopInstr(softStopInstr), .clockStartInstr(clockStartInstr), .domainLoadInstr(domainLoadInstr),
        .domainData(domainData), .delayLoadInstr(delayLoadInstr), .delayData(delayData),
        .statusReadInstr(statusReadInstr), .flushReq(flushReq), .flushDone(flushDone),
        .debugHardReq(debugHardReq), .debugSoftReq(debugSoftReq), .coreSelect(coreSelect),
        .coreQuiescent(coreQuiescent), .domainStop(domainStop), .clocksStopped(clocksStopped),
        .statusData(statusData), .statusValid(statusValid), .domainSelRead(domainSelRead));

    csq_core_model model (.ref_clk(ref_clk), .rst(rst), .parkReq(parkReq), .lat(lat),
        .coreQuiescent(coreQuiescent));

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step

    function automatic int lowBit(input logic [31:0] v);
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                return i;
            end
        end
        return 0;
    endfunction : lowBit

    // Selected bits plus k serial steps after the start, wrapping
    function automatic logic [31:0] walkMask(input logic [31:0] sel, input int st, input int k);
        logic [31:0] m;
        m = sel;
        for (int i = 1; i <= k; i++) begin
            m[(st + i) % 32] = 1'b1;
        end
        return m;
    endfunction : walkMask

    task automatic waitUntil(input int what, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((what == 0 && clocksStopped === 1'b1) || (what == 1 && domainStop === '0)) begin
                break;
            end
            step();
        end
        if (i == lim) begin
            fails++;
            $display("CHECK FAILED wait %0d exp=1 got=0", what);
            end_of_test();
        end
    endtask : waitUntil

    task automatic loadReg(input bit isDelay, input logic [31:0] v);
        delayLoadInstr = isDelay;
        domainLoadInstr = !isDelay;
        delayData = v[6:0];
        domainData = v;
        step();
        delayLoadInstr = 1'b0;
        domainLoadInstr = 1'b0;
        step();
    endtask : loadReg

    task automatic restart(input bit viaFlush);
        flushDone = viaFlush;
        clockStartInstr = !viaFlush;
        step();
        flushDone = 1'b0;
        clockStartInstr = 1'b0;
    endtask : restart

    task automatic readStatus(input csq_state_t st, input logic stopped);
        statusReadInstr = 1'b1;
        step();
        statusReadInstr = 1'b0;
        `CHK("status valid", 1'b1, statusValid)
        `CHK("status state", st, statusData.state)
        `CHK("status busy", st != CSQ_IDLE, statusData.busy)
        `CHK("status stopped", stopped, statusData.clocksStopped)
        step();
        `CHK("status pulse", 1'b0, statusValid)
    endtask : readStatus

    task automatic hardRun(input int trig, input logic [31:0] sel, input int d, input bit viaFlush);
        logic [31:0] eff;
        int st;
        int g;
        eff = (sel == '0) ? 32'h1 : sel;
        st = lowBit(eff);
        g = (d < 0) ? 128 : d + 1;
        loadReg(1'b0, sel);
        if (d >= 0) begin
            loadReg(1'b1, 32'(d));
        end
        hardStopInstr = (trig == 0);
        flushReq = (trig == 1);
        debugHardReq = (trig == 2);
        step();
        hardStopInstr = 1'b0;
        flushReq = 1'b0;
        debugHardReq = 1'b0;
        for (int n = 2; n <= 2 + 31 * g; n++) begin
            step();
            hardStopInstr = (n == 3);
            `CHK("stop mask", walkMask(eff, st, (n - 2) / g), domainStop)
            `CHK("early stopped", 1'b0, clocksStopped && n < 2 + 31 * g)
        end
        waitUntil(0, g + 8);
        readStatus(CSQ_STOPPED, 1'b1);
        `CHK("held mask", 32'hffff_ffff, domainStop)
        restart(viaFlush);
        `CHK("restart flag", 1'b0, clocksStopped)
        if ($countones(eff) == 1) begin
            for (int n = 2; n <= 2 + 31 * g; n++) begin
                step();
                `CHK("release mask", ~walkMask(eff, st, (n - 2) / g), domainStop)
            end
        end
        waitUntil(1, 40 * g);
        // Last release tick still follows the last cleared domain
        repeat (g) step();
        readStatus(CSQ_IDLE, 1'b0);
    endtask : hardRun

    task automatic softRun(input logic [7:0] tgt, input bit viaDebug, input logic [2:0] l);
        loadReg(1'b0, 32'h0);
        loadReg(1'b1, 32'h0);
        lat = l;
        coreSelect = tgt;
        debugSoftReq = viaDebug ? tgt : 8'h00;
        softStopInstr = !viaDebug;
        step();
        debugSoftReq = '0;
        softStopInstr = 1'b0;
        // Cores still running, so nothing may stop, not even a late hard request
        for (int n = 1; n <= 40; n++) begin
            step();
            hardStopInstr = (n == 38);
            `CHK("soft wait mask", 32'h0, domainStop)
        end
        parkReq = tgt;
        waitUntil(0, 20);
        `CHK("soft mask", {24'h0, tgt}, domainStop)
        readStatus(CSQ_STOPPED, 1'b1);
        restart(1'b0);
        waitUntil(1, 60);
        parkReq = '0;
        // Sequencer walks all domains before it accepts the next stop
        repeat (32) step();
        readStatus(CSQ_IDLE, 1'b0);
    endtask : softRun

    initial begin
        logic [31:0] sel;
        void'($urandom(15155));
        repeat (3) step();
        rst = 1'b0;
        `CHK("reset stop", 32'h0, domainStop)
        `CHK("reset select", DOMAIN_SEL_RESET, domainSelRead)
        readStatus(CSQ_IDLE, 1'b0);
        restart(1'b0);
        repeat (3) step();
        `CHK("idle restart", 32'h0, domainStop)
        sel = $urandom();
        loadReg(1'b0, sel);
        step();
        `CHK("select load", sel, domainSelRead)
        hardRun(0, 32'h0000_0001, -1, 1'b0);
        hardRun(1, 32'hffff_ffff, 0, 1'b1);
        hardRun(2, 32'h0, 1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            sel = (i < 3) ? (32'h1 << ($urandom() % 32)) : $urandom();
            hardRun(i % 3, sel, $urandom() % 4, i[0]);
        end
        softRun(8'h24, 1'b0, 3'h0);
        softRun(8'h81 | 8'($urandom()), 1'b1, 3'h7);
        end_of_test();
    end
endmodule : csq_clock_stop_sequencer_test
`default_nettype wire
